/* tw_pkg.sv */
package tw_pkg;
  // instruction cycle length in oscillator (mclk) periods
  localparam int          OSC_PER_INSTR = 4;
  localparam logic [1:0]  PH_LAST       = 2'(OSC_PER_INSTR - 1);
  // special file addresses
  localparam logic [4:0]  F_TMR         = 5'h01;
  localparam logic [4:0]  F_PCL         = 5'h02;
  localparam logic [4:0]  F_STAT        = 5'h03;
  localparam logic [4:0]  F_GPIO        = 5'h06;
  // status bit positions and the option prescaler-assign bit
  localparam int          ST_C          = 0;
  localparam int          ST_DCY        = 1;
  localparam int          ST_Z          = 2;
  localparam int          ST_PWDN       = 3;
  localparam int          ST_TOUT       = 4;
  localparam int          OPT_PSA       = 3;
  // reset values
  localparam logic [7:0]  STAT_RST      = 8'h18;
  localparam logic [7:0]  DIR_RST       = 8'hFF;
  localparam logic [7:0]  OPT_RST       = 8'hFF;
  localparam logic [8:0]  PC_RST        = 9'h000;
  // whole-word control opcodes
  localparam logic [11:0] OP_OPTION     = 12'h002;
  localparam logic [11:0] OP_SLEEP      = 12'h003;
  localparam logic [11:0] OP_CLRWDT     = 12'h004;
  localparam logic [11:0] OP_DIR_LOAD   = 12'h006;
  // byte-oriented operation codes {opcode[9:8], opcode[7:6]}
  localparam logic [3:0]  BO_SUB        = 4'h2;
  localparam logic [3:0]  BO_DEC        = 4'h3;
  localparam logic [3:0]  BO_IOR        = 4'h4;
  localparam logic [3:0]  BO_AND        = 4'h5;
  localparam logic [3:0]  BO_XOR        = 4'h6;
  localparam logic [3:0]  BO_ADD        = 4'h7;
  localparam logic [3:0]  BO_MOV        = 4'h8;
  localparam logic [3:0]  BO_COM        = 4'h9;
  localparam logic [3:0]  BO_INC        = 4'hA;
  localparam logic [3:0]  BO_DSZ        = 4'hB;
  localparam logic [3:0]  BO_ROTR       = 4'hC;
  localparam logic [3:0]  BO_ROTL       = 4'hD;
  localparam logic [3:0]  BO_SWP        = 4'hE;
  localparam logic [3:0]  BO_ISZ        = 4'hF;
  // APB register byte addresses and control register bit positions
  localparam logic [11:0] A_CTRL        = 12'h000;
  localparam logic [11:0] A_CORE        = 12'h004;
  localparam logic [11:0] A_PC          = 12'h008;
  localparam logic [11:0] A_PORT        = 12'h00C;
  localparam int          CT_RUN        = 0;
  localparam int          CT_WAKE       = 1;
endpackage

/* tw_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module tw_decoder
  import tw_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [8:0]  progAddr,
  input  wire logic [11:0] progData,
  input  wire logic [7:0]  gpioIn,
  output logic      [7:0]  gpioOut,
  output logic      [7:0]  gpioOeN,
  output logic             sleeping
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] phase;
  logic       run, sleep, flush, rdy;
  logic [8:0] pc, stk0, stk1;
  logic [7:0] w, stat, opt, dirLat, gpioLat, tmr, presc, gpioS1, gpioS2;
  logic [7:0] regFile [0:31];

  // instruction cycle strobe: one mclk in four while running
  wire active = run & ~sleep;
  wire exec   = ce & active & (phase == PH_LAST);
  wire go     = exec & ~flush;

  // field split of the fetched word
  wire [11:0] ir   = progData;
  wire [3:0]  hi   = ir[11:8];
  wire [3:0]  bop  = {ir[9:8], ir[7:6]};
  wire        d    = ir[5];
  wire [4:0]  fa   = ir[4:0];
  wire [2:0]  bsel = ir[7:5];
  wire [7:0]  k    = ir[7:0];

  // instruction classes
  wire isMovwf  = ir[11:5] == 7'h01;
  wire isClrw   = ir[11:5] == 7'h02;
  wire isClrf   = ir[11:5] == 7'h03;
  wire byteOp   = (hi[3:2] == 2'b00) & ~(hi == 4'h0 & ~ir[7]);
  wire isBitWr  = hi[3:1] == 3'b010;
  wire isBitTst = hi[3:1] == 3'b011;
  wire isRet    = hi == 4'h8;
  wire isCall   = hi == 4'h9;
  wire isGoto   = hi[3:1] == 3'b101;
  wire isLitW   = hi[3:2] == 2'b11;
  wire isSleep  = ir == OP_SLEEP;
  wire isClrwdt = ir == OP_CLRWDT;
  wire isOption = ir == OP_OPTION;
  wire isDirLd  = ir == OP_DIR_LOAD;

  ////////////////////////////////////////////////////////////////////////////
  // file read: the port reads its pins, so read-modify-write sees pin levels
  wire [7:0] fv = (fa == F_TMR)  ? tmr :
                  (fa == F_PCL)  ? pc[7:0] :
                  (fa == F_STAT) ? stat :
                  (fa == F_GPIO) ? gpioS2 :
                  regFile[fa];

  wire [8:0] addS = {1'b0, w} + {1'b0, fv};
  wire [8:0] subS = {1'b0, fv} - {1'b0, w};
  wire [4:0] addN = {1'b0, w[3:0]} + {1'b0, fv[3:0]};
  wire [4:0] subN = {1'b0, fv[3:0]} - {1'b0, w[3:0]};

  // byte-oriented arithmetic and flag effects
  logic [7:0] res;
  logic       cNew, dcNew, updC, updDC, updZ;
  always_comb begin
    res   = fv;
    cNew  = stat[ST_C];
    dcNew = stat[ST_DCY];
    updC  = 1'b0;
    updDC = 1'b0;
    updZ  = 1'b0;
    case (bop)
      BO_SUB: begin
        res   = subS[7:0];
        cNew  = ~subS[8];
        dcNew = ~subN[4];
        {updC, updDC, updZ} = 3'h7;
      end
      BO_ADD: begin
        res   = addS[7:0];
        cNew  = addS[8];
        dcNew = addN[4];
        {updC, updDC, updZ} = 3'h7;
      end
      BO_IOR: begin
        res  = w | fv;
        updZ = 1'b1;
      end
      BO_AND: begin
        res  = w & fv;
        updZ = 1'b1;
      end
      BO_XOR: begin
        res  = w ^ fv;
        updZ = 1'b1;
      end
      BO_DEC: begin
        res  = fv - 8'h01;
        updZ = 1'b1;
      end
      BO_INC: begin
        res  = fv + 8'h01;
        updZ = 1'b1;
      end
      BO_MOV: updZ = 1'b1;
      BO_COM: begin
        res  = ~fv;
        updZ = 1'b1;
      end
      BO_DSZ: res = fv - 8'h01;
      BO_ISZ: res = fv + 8'h01;
      BO_ROTR: begin
        res  = {stat[ST_C], fv[7:1]};
        cNew = fv[0];
        updC = 1'b1;
      end
      BO_ROTL: begin
        res  = {fv[6:0], stat[ST_C]};
        cNew = fv[7];
        updC = 1'b1;
      end
      BO_SWP: res = {fv[3:0], fv[7:4]};
      default: res = fv;
    endcase
  end

  // bit and literal results
  wire [7:0] bmask  = 8'h01 << bsel;
  wire [7:0] bitRes = hi[0] ? (fv | bmask) : (fv & ~bmask);
  wire       bitVal = fv[bsel];
  wire [7:0] litRes = (hi == 4'hE) ? (w & k) :
                      (hi == 4'hD) ? (w | k) :
                      (hi == 4'hF) ? (w ^ k) : k;
  wire       litZ   = hi == 4'hD || hi == 4'hE || hi == 4'hF;

  // write-back routing by the destination bit
  wire [7:0] fwv = isMovwf ? w : isClrf ? 8'h00 : isBitWr ? bitRes : res;
  wire [7:0] wwv = isClrw ? 8'h00 : (isLitW | isRet) ? litRes : res;
  wire wrF   = go & ((byteOp & d) | isMovwf | isClrf | isBitWr);
  wire wrW   = go & ((byteOp & ~d) | isClrw | isLitW | isRet);
  wire zSet  = byteOp ? updZ : (isClrw | isClrf | (isLitW & litZ));
  wire zVal  = (isClrw | isClrf) ? 1'b1 : isLitW ? (litRes == 8'h00) : (res == 8'h00);
  wire wrTmr = wrF & (fa == F_TMR);
  wire wrPcl = wrF & (fa == F_PCL);

  // skip decision for test-and-skip opcodes
  wire skipZ = byteOp & ((bop == BO_DSZ) | (bop == BO_ISZ)) & (res == 8'h00);
  wire skipB = isBitTst & (hi[0] ? bitVal : ~bitVal);
  wire skip  = skipZ | skipB;
  wire jump  = isGoto | isCall | isRet | wrPcl;

  ////////////////////////////////////////////////////////////////////////////
  // phase counter: four mclk per instruction cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase <= 2'h0;
    end else if (ce && active) begin
      phase <= phase + 2'h1;
    end
  end

  // program counter, stack and dead cycle after a jump or skip
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc    <= PC_RST;
      stk0  <= PC_RST;
      stk1  <= PC_RST;
      flush <= 1'b0;
    end else if (exec && flush) begin
      flush <= 1'b0;
    end else if (go) begin
      flush <= jump | skip;
      if (isGoto) begin
        pc <= ir[8:0];
      end else if (isCall) begin
        stk1 <= stk0;
        stk0 <= pc + 9'h001;
        pc   <= {1'b0, k};
      end else if (isRet) begin
        stk0 <= stk1;
        pc   <= {1'b0, stk0[7:0]};
      end else if (wrPcl) begin
        pc <= {1'b0, fwv};
      end else if (skip) begin
        pc <= pc + 9'h002;
      end else begin
        pc <= pc + 9'h001;
      end
    end
  end

  // accumulator
  always_ff @(posedge mclk) begin
    if (srst) begin
      w <= 8'h00;
    end else if (wrW) begin
      w <= wwv;
    end
  end

  // status: flag updates win over a plain write of the status file
  always_ff @(posedge mclk) begin
    if (srst) begin
      stat <= STAT_RST;
    end else if (go) begin
      if (wrF && fa == F_STAT) begin
        stat <= {fwv[7:5], stat[ST_TOUT], stat[ST_PWDN], fwv[2:0]};
      end
      if (byteOp && updC) stat[ST_C] <= cNew;
      if (byteOp && updDC) stat[ST_DCY] <= dcNew;
      if (zSet) stat[ST_Z] <= zVal;
      if (isSleep) begin
        stat[ST_PWDN] <= 1'b0;
        stat[ST_TOUT] <= 1'b1;
      end
      if (isClrwdt) begin
        stat[ST_PWDN] <= 1'b1;
        stat[ST_TOUT] <= 1'b1;
      end
    end
  end

  // general file registers; special addresses live in their own flops
  wire plainF = fa != F_TMR && fa != F_PCL && fa != F_STAT && fa != F_GPIO;
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        regFile[i] <= 8'h00;
      end
    end else if (wrF && plainF) begin
      regFile[fa] <= fwv;
    end
  end

  // port latch, direction latch and option register
  always_ff @(posedge mclk) begin
    if (srst) begin
      gpioLat <= 8'h00;
      dirLat  <= DIR_RST;
      opt     <= OPT_RST;
    end else if (go) begin
      if (wrF && fa == F_GPIO) gpioLat <= fwv;
      if (isDirLd) dirLat <= w;
      if (isOption) opt <= w;
    end
  end

  // timer and prescaler; prescaler divides by 2^(opt[2:0]+1)
  wire       psaTmr = ~opt[OPT_PSA];
  wire [8:0] pm9    = (9'h002 << opt[2:0]) - 9'h001;
  wire       tick   = exec & (~psaTmr | ((presc & pm9[7:0]) == pm9[7:0]));
  always_ff @(posedge mclk) begin
    if (srst) begin
      tmr   <= 8'h00;
      presc <= 8'h00;
    end else begin
      if (wrTmr) tmr <= fwv;
      else if (tick) tmr <= tmr + 8'h01;
      if ((wrTmr && psaTmr) || (go && isClrwdt && !psaTmr)) presc <= 8'h00;
      else if (exec && psaTmr) presc <= presc + 8'h01;
    end
  end

  // pin synchroniser; stage one feeds stage two only
  always_ff @(posedge mclk) begin
    if (srst) begin
      gpioS1 <= 8'h00;
      gpioS2 <= 8'h00;
    end else if (ce) begin
      gpioS1 <= gpioIn;
      gpioS2 <= gpioS1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data captured from flops
  wire mapped = paddr == A_CTRL || paddr == A_CORE || paddr == A_PC || paddr == A_PORT;
  wire apbWr  = psel & penable & pwrite & rdy & ce;
  wire [31:0] rdMux = (paddr == A_CTRL) ? {31'h0, run} :
                      (paddr == A_CORE) ? {15'h0, sleep, stat, w} :
                      (paddr == A_PC)   ? {23'h0, pc} :
                      (paddr == A_PORT) ? {8'h0, gpioS2, dirLat, gpioLat} : 32'h0;
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdy    <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      rdy    <= psel & penable & ~rdy;
      prdata <= rdMux;
    end
  end

  // run control and standby; a wake write leaves standby
  always_ff @(posedge mclk) begin
    if (srst) begin
      run   <= 1'b0;
      sleep <= 1'b0;
    end else begin
      if (apbWr && paddr == A_CTRL) run <= pwdata[CT_RUN];
      if (go && isSleep) sleep <= 1'b1;
      else if (apbWr && paddr == A_CTRL && pwdata[CT_WAKE]) sleep <= 1'b0;
    end
  end

  assign pready   = rdy;
  assign pslverr  = rdy & ~mapped;
  assign progAddr = pc;
  assign gpioOut  = gpioLat;
  assign gpioOeN  = dirLat;
  assign sleeping = sleep;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_skipTaken;
    go && skip;
  endsequence
  sequence s_deadCycle;
    flush && pc == $past(pc) + 9'h002;
  endsequence

  a_skip_dead_cycle: assert property (s_skipTaken |=> s_deadCycle)
    else $error("skip did not advance pc by two with a dead cycle");
  a_instr_period: assert property (exec |=> !exec [*3])
    else $error("instruction strobe closer than four clocks");
  a_add_result: assert property (go && byteOp && bop == BO_ADD && !d |=>
    w == 8'($past(w) + $past(fv)))
    else $error("add to acc gave wrong sum");
  a_bit_flags: assert property (go && (isBitWr || isBitTst) && fa != F_STAT |=>
    stat == $past(stat))
    else $error("bit operation changed status");
  a_pc_bit8: assert property (go && (isCall || isRet || wrPcl) |=> !pc[8])
    else $error("pc bit 8 not cleared");
  a_direction_latch_load_load: assert property (go && isDirLd |=> gpioOeN == $past(w))
    else $error("direction latch not loaded from acc");
  a_presc_clear: assert property (wrTmr && psaTmr |=> presc == 8'h00)
    else $error("prescaler not cleared on timer write");
  a_sleep_flags: assert property (go && isSleep |=>
    sleeping && !stat[ST_PWDN] && stat[ST_TOUT])
    else $error("standby flags wrong");
  a_return_with_literal_two: assert property (go && isRet |=> w == $past(k) && flush ##4 !flush)
    else $error("return with literal not two cycles");
  a_litor_zero: assert property (go && hi == 4'hD |=> stat[ST_Z] == (w == 8'h00))
    else $error("literal or zero flag wrong");
endmodule
`default_nettype wire

/* tw_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// program memory model: one 12-bit word per address, answers at once
module tw_prog_mem
  import tw_pkg::*;
(
  input  wire logic [8:0]  progAddr,
  output logic      [11:0] progData
);
  // bench fills this array just after reset is released, while the run bit is still clear
  logic [11:0] mem [0:511];

  // combinational read, well inside the four-cycle budget of the core
  assign progData = mem[progAddr];
endmodule
`default_nettype wire

/* tw_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tw_decoder_tb
  import tw_pkg::*;
;
  logic        mclk, srst, ce, psel, penable, pwrite, pready, pslverr, sleeping;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  logic [8:0]  progAddr;
  logic [11:0] progData;
  logic [7:0]  gpioIn, gpioOut, gpioOeN;
  int          failures, n_checks;

  tw_decoder i_tw_decoder (.mclk(mclk), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .progAddr(progAddr), .progData(progData), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOeN(gpioOeN), .sleeping(sleeping));
  tw_prog_mem i_tw_prog_mem (.progAddr(progAddr), .progData(progData));

  // free-running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic checkVal(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask

  // one apb transfer; waits for pready under a bound, the slave's latency is not assumed
  task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic e);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      failures++;
      tally_and_finish();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset, load a program as {addr,word} pairs, run until pc parks, check core state
  task automatic runProg(input logic [20:0] p[$], input logic [7:0] expW,
                         input logic [7:0] expSt, input logic [8:0] expPc);
    int k;
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    foreach (i_tw_prog_mem.mem[j]) i_tw_prog_mem.mem[j] = 12'h000;
    foreach (p[j]) i_tw_prog_mem.mem[p[j][20:12]] = p[j][11:0];
    apbXfer(1'b1, A_CTRL, 32'h1, rd, er);
    k = 0;
    while (progAddr !== expPc && sleeping !== 1'b1 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 400) begin
      failures++;
      tally_and_finish();
    end
    // three instruction cycles let the parking branch and its dead cycle settle
    repeat (12) @(posedge mclk);
    apbXfer(1'b0, A_CORE, 32'h0, rd, er);
    checkVal("acc", {24'h0, expW}, {24'h0, rd[7:0]});
    checkVal("status", {24'h0, expSt}, {24'h0, rd[15:8]});
    // a standby program has no parked pc to compare
    if (expPc != 9'h1FF) begin
      apbXfer(1'b0, A_PC, 32'h0, rd, er);
      checkVal("pc", {23'h0, expPc}, {23'h0, rd[8:0]});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gpioIn = 8'h0F;
    failures = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    apbXfer(1'b0, A_CORE, 32'h0, rd, er);
    checkVal("core reset", {8'h0, 8'h0, STAT_RST, 8'h00}, rd);
    apbXfer(1'b0, 12'h010, 32'h0, rd, er);
    checkVal("unmapped err", 32'h1, {31'h0, er});
    checkVal("unmapped data", 32'h0, rd);
    runProg('{21'h000C38, 21'h001030, 21'h002CC8, 21'h0031D0, 21'h004A04},
            8'h00, 8'h1F, 9'h004);
    runProg('{21'h000C05, 21'h001030, 21'h002C0B, 21'h0031F0, 21'h004210, 21'h005A05},
            8'h10, 8'h1A, 9'h005);
    runProg('{21'h000503, 21'h001C0F, 21'h002031, 21'h003CF0, 21'h004111, 21'h005191,
              21'h006151, 21'h007A07}, 8'h00, 8'h1D, 9'h007);
    runProg('{21'h000C01, 21'h001032, 21'h0022D2, 21'h003C55, 21'h004A04},
            8'h00, 8'h18, 9'h004);
    runProg('{21'h000CFE, 21'h001032, 21'h0023D2, 21'h003A03, 21'h004A04},
            8'hFF, 8'h18, 9'h003);
    runProg('{21'h000C81, 21'h001033, 21'h002373, 21'h003313, 21'h004A04},
            8'h81, 8'h18, 9'h004);
    // skipped words OR in bits that the final value lacks, so a missed skip shows in acc
    runProg('{21'h0005F4, 21'h001534, 21'h002434, 21'h003634, 21'h004D40, 21'h0057F4,
              21'h006D80, 21'h0076F4, 21'h008D33, 21'h009A09},
            8'h33, 8'h18, 9'h009);
    runProg('{21'h000CF0, 21'h001D0F, 21'h002F3C, 21'h003E3C, 21'h004A04},
            8'h00, 8'h1C, 9'h004);
    runProg('{21'h000CF0, 21'h001D0F, 21'h002F3C, 21'h003A03},
            8'hC3, 8'h18, 9'h003);
    // prescaler on the timer at divide by two; without the clear on the timer write
    // the timer would tick once before it is read back
    runProg('{21'h000C00, 21'h001002, 21'h002C05, 21'h003000, 21'h004021, 21'h005000,
              21'h006201, 21'h007A07}, 8'h05, 8'h18, 9'h007);
    runProg('{21'h000B00, 21'h100904, 21'h00485A, 21'h001A01},
            8'h5A, 8'h18, 9'h001);
    runProg('{21'h000C77, 21'h001003, 21'h002A02}, 8'h77, 8'h10, 9'h1FF);
    checkVal("standby", 32'h1, {31'h0, sleeping});
    runProg('{21'h000CA5, 21'h001006, 21'h002A02}, 8'hA5, 8'h18, 9'h002);
    checkVal("direction", 32'hA5, {24'h0, gpioOeN});
    runProg('{21'h000CF0, 21'h001026, 21'h002226, 21'h003A03},
            8'hF0, 8'h18, 9'h003);
    checkVal("port latch", 32'h0F, {24'h0, gpioOut});
    apbXfer(1'b0, A_CTRL, 32'h0, rd, er);
    checkVal("run bit", 32'h1, rd);
    tally_and_finish();
  end
endmodule
`default_nettype wire
